/* File: src/iocpc_pkg.sv */
// constants shared by the i/o line configuration and position compare block
package iocpc_pkg;
   // command codes
   localparam logic [7:0] CODE_CFG = 8'hbc;
   localparam logic [7:0] CODE_CLR = 8'hce;
   localparam logic [7:0] CODE_PCP = 8'hf5;
   localparam logic [7:0] CODE_LS = 8'h4e;
   localparam logic [7:0] CODE_LT = 8'h4f;
   // configure-line mode field, signed 16 bit
   localparam logic [15:0] MODE_IN = 16'hffff;
   localparam logic [15:0] MODE_LOW = 16'h0000;
   localparam logic [15:0] MODE_HIGH = 16'h0001;
   localparam logic [15:0] MODE_PU = 16'hfffe;
   localparam logic [15:0] MODE_PD = 16'hfffd;
   localparam logic [15:0] MODE_PI = 16'hfffc;
   // line numbering: standard lines 1..N_STD, open collector lines 101..116
   localparam int N_STD = 8;
   localparam int N_EXT = 16;
   localparam int N_LINE = N_STD + N_EXT;
   localparam logic [15:0] STD_FIRST = 16'h0001;
   localparam logic [15:0] STD_LAST = 16'h0008;
   localparam logic [15:0] EXT_FIRST = 16'h0065;
   localparam logic [15:0] EXT_LAST = 16'h0074;
   localparam logic [N_LINE-1:0] EXT_MASK = 24'hffff00;
   // user data registers
   localparam int N_REG = 32;
   localparam int REG_AW = 5;
   // reset values: all lines inputs, pulls inactive
   localparam logic [N_LINE-1:0] LINE_RST = 24'h000000;
   // compare tick
   localparam int TICK_NS = 120000;
   localparam int CLK_NS = 20;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int TICK_W = 13;
endpackage

/* File: src/iocpc_top.sv */
// i/o line configuration with position compare and limit switch engines
// Contract
// RL1 - configure-line command 188 sets one addressed line as input or output
// RL2 - after reset every line is an input
// RL3 - mode -1 input, 0 output low, 1 output high; output loads level
// RL4 - lines 101..116: mode 0 turns low driver on, -1 and 1 off
// RL5 - open collector lines stay readable while driven, for overcurrent checks
// RL6 - modes -2 pull-up, -3 pull-down, -4 pull inactive; set while input
// RL7 - clear-line command 206 drives line low, making an input an output
// RL8 - position compare 245 toggles line 1 on each trigger crossing
// RL9 - positive crossing adds modulo to trigger, negative crossing subtracts it
// RL10 - zero modulo keeps trigger fixed; line 1 shows position >= trigger
// RL11 - trigger is in named data register, modulo in the next one
// RL12 - host sets line 1 as output with start level before compare
// RL13 - compare evaluated once per 120 us tick
// RL14 - compare runs until a compare command names data register zero
// RL15 - limit switch 78 takes trigger table from start register and count
// RL16 - limit switch drives chosen line from initial level; line 0 disables
// RL17 - each tick position is compared with current point; level switches
// RL18 - trigger adjust command enables, disables, recounts without resetting modulo
// RL19 - after last point, wrap to first point offset by the modulo span
// RL20 - accepted commands answer with an acknowledge only
`timescale 1ns/1ns
module iocpc_top
   import iocpc_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic cmd_valid_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic [15:0] cmd_arg0_in,
   input wire logic [15:0] cmd_arg1_in,
   input wire logic [15:0] cmd_arg2_in,
   input wire logic [15:0] cmd_arg3_in,
   output logic cmd_ack_out,
   input wire logic [31:0] pos_in,
   input wire logic usr_wr_in,
   input wire logic [REG_AW-1:0] usr_addr_in,
   input wire logic [31:0] usr_data_in,
   output logic [31:0] usr_rdata_out,
   input wire logic [N_LINE-1:0] line_in,
   output logic [N_LINE-1:0] line_out,
   output logic [N_LINE-1:0] line_oe_n_out,
   output logic [N_LINE-1:0] pull_en_out,
   output logic [N_LINE-1:0] pull_up_out,
   output logic [N_LINE-1:0] line_state_out,
   output logic pc_active_out,
   output logic ls_active_out
);

   // maps a line number to {valid, index}
   function automatic logic [5:0] line_map(input logic [15:0] n);
      logic [5:0] r;
      r = 6'h00;
      if (n >= STD_FIRST && n <= STD_LAST) begin
         r = {1'b1, 5'(n - STD_FIRST)};
      end else if (n >= EXT_FIRST && n <= EXT_LAST) begin
         r = {1'b1, 5'(n - EXT_FIRST + 16'(N_STD))};
      end
      return r;
   endfunction

   // returns {drive, level} for logic level v; open collector lines only sink
   function automatic logic [1:0] put_lvl(input logic ext, input logic d, input logic v);
      return ext ? {~v, 1'b0} : {d, v};
   endfunction

   logic signed [31:0] mem [N_REG];
   logic [N_LINE-1:0] drv, lvl, pen, pup, sync1, sync2;
   logic [N_LINE-1:0] next_drv, next_lvl, next_pen, next_pup;
   logic pc_en, next_pc_en, ls_en, next_ls_en, ack, next_ack, tick;
   logic [REG_AW-1:0] pc_reg, next_pc_reg, ls_start, next_ls_start;
   logic [REG_AW-1:0] ls_cnt, next_ls_cnt, ls_ptr, next_ls_ptr;
   logic [4:0] ls_idx, next_ls_idx;
   logic signed [31:0] ls_base, next_ls_base, pos_prev, next_pos_prev;
   logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
   logic we;
   logic [REG_AW-1:0] waddr;
   logic signed [31:0] wdata;
   logic [5:0] cmd_sel;

   assign cmd_sel = line_map(cmd_arg0_in);
   assign tick = tick_cnt == TICK_W'(TICK_CYCLES - 1);

   // pin inputs pass two flops; readback works while driven RL5
   always_ff @(posedge ref_clk_in) begin
      sync1 <= line_in;
      sync2 <= sync1;
   end
   assign line_state_out = sync2;

   // user data registers; the compare engine writes back its trigger
   always_ff @(posedge ref_clk_in) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (usr_wr_in) begin
         mem[usr_addr_in] <= usr_data_in;
      end
      usr_rdata_out <= mem[usr_addr_in];
   end

   // next state: engines first, then commands so a command overrides a tick
   always_comb begin
      logic signed [31:0] trig, modv, tgt;
      logic lv;
      trig = mem[pc_reg]; // RL11
      modv = mem[REG_AW'(pc_reg + 5'h01)]; // RL11
      tgt = mem[REG_AW'(ls_start + ls_ptr)] + ls_base;
      lv = EXT_MASK[ls_idx] ? ~drv[ls_idx] : lvl[ls_idx];
      next_drv = drv;
      next_lvl = lvl;
      next_pen = pen;
      next_pup = pup;
      next_pc_en = pc_en;
      next_pc_reg = pc_reg;
      next_ls_en = ls_en;
      next_ls_idx = ls_idx;
      next_ls_start = ls_start;
      next_ls_cnt = ls_cnt;
      next_ls_ptr = ls_ptr;
      next_ls_base = ls_base;
      next_ack = 1'b0;
      we = 1'b0;
      waddr = pc_reg;
      wdata = trig;
      // one evaluation per tick, so output may lag a crossing by a tick RL13
      next_tick_cnt = tick ? '0 : TICK_W'(tick_cnt + 1'b1); // RL13
      next_pos_prev = tick ? $signed(pos_in) : pos_prev;
      // line 1 must already be an output when this runs RL12
      if (pc_en && tick) begin
         if (modv == 0) begin
            next_lvl[0] = $signed(pos_in) >= trig; // RL10
         end else if (pos_prev < trig && $signed(pos_in) >= trig) begin
            next_lvl[0] = ~lvl[0]; // RL8
            we = 1'b1;
            wdata = trig + modv; // RL9
         end else if (pos_prev >= trig && $signed(pos_in) < trig) begin
            next_lvl[0] = ~lvl[0]; // RL8
            we = 1'b1;
            wdata = trig - modv; // RL9
         end
      end
      // limit switch table walk; a tick with position at or past the current point advances the pointer
      if (ls_en && tick && $signed(pos_in) >= tgt) begin
         {next_drv[ls_idx], next_lvl[ls_idx]} = put_lvl(EXT_MASK[ls_idx], drv[ls_idx], ~lv); // RL17
         if (ls_ptr == REG_AW'(ls_cnt - 5'h01)) begin
            next_ls_ptr = '0; // RL19
            next_ls_base = ls_base + mem[REG_AW'(ls_start + ls_cnt)]; // RL19
         end else begin
            next_ls_ptr = REG_AW'(ls_ptr + 5'h01);
         end
      end
      if (cmd_valid_in) begin
         case (cmd_code_in)
            CODE_CFG: begin
               if (cmd_sel[5]) begin
                  next_ack = 1'b1; // RL20
                  case (cmd_arg1_in)
                     MODE_IN: next_drv[cmd_sel[4:0]] = 1'b0; // RL1 RL3 RL4
                     MODE_LOW: begin
                        next_drv[cmd_sel[4:0]] = 1'b1; // RL3 RL4
                        next_lvl[cmd_sel[4:0]] = 1'b0;
                     end
                     MODE_HIGH: begin
                        next_drv[cmd_sel[4:0]] = ~EXT_MASK[cmd_sel[4:0]]; // RL3 RL4
                        next_lvl[cmd_sel[4:0]] = ~EXT_MASK[cmd_sel[4:0]];
                     end
                     MODE_PU: begin
                        next_pen[cmd_sel[4:0]] = 1'b1; // RL6
                        next_pup[cmd_sel[4:0]] = 1'b1;
                     end
                     MODE_PD: begin
                        next_pen[cmd_sel[4:0]] = 1'b1; // RL6
                        next_pup[cmd_sel[4:0]] = 1'b0;
                     end
                     MODE_PI: next_pen[cmd_sel[4:0]] = 1'b0; // RL6
                     default: next_ack = 1'b0;
                  endcase
               end
            end
            CODE_CLR: begin
               if (cmd_sel[5]) begin
                  next_drv[cmd_sel[4:0]] = 1'b1; // RL7
                  next_lvl[cmd_sel[4:0]] = 1'b0; // RL7
                  next_ack = 1'b1; // RL20
               end
            end
            CODE_PCP: begin
               next_pc_en = cmd_arg0_in != 16'h0000; // RL14
               next_pc_reg = cmd_arg0_in[REG_AW-1:0];
               next_ack = 1'b1; // RL20
            end
            CODE_LS, CODE_LT: begin
               if (cmd_arg0_in == 16'h0000) begin
                  next_ls_en = 1'b0; // RL16 RL18
                  next_ack = 1'b1;
               end else if (cmd_sel[5]) begin
                  next_ack = 1'b1; // RL20
                  next_ls_idx = cmd_sel[4:0];
                  {next_drv[cmd_sel[4:0]], next_lvl[cmd_sel[4:0]]} =
                     put_lvl(EXT_MASK[cmd_sel[4:0]], drv[cmd_sel[4:0]], cmd_arg1_in[0]); // RL16
                  if (cmd_code_in == CODE_LS) begin
                     next_ls_start = cmd_arg2_in[REG_AW-1:0]; // RL15
                     next_ls_cnt = cmd_arg3_in[REG_AW-1:0]; // RL15
                     next_ls_ptr = '0;
                     next_ls_base = '0;
                     next_ls_en = cmd_arg3_in[REG_AW-1:0] != '0;
                  end else begin
                     // modulo base is kept across a recount RL18
                     next_ls_cnt = cmd_arg2_in[REG_AW-1:0]; // RL18
                     next_ls_en = cmd_arg2_in[REG_AW-1:0] != '0; // RL18
                     if (ls_ptr >= cmd_arg2_in[REG_AW-1:0]) begin
                        next_ls_ptr = '0;
                     end
                  end
               end
            end
            default: next_ack = 1'b0;
         endcase
      end
   end

   // state registers
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         drv <= LINE_RST; // RL2
         lvl <= LINE_RST;
         pen <= LINE_RST;
         pup <= LINE_RST;
         pc_en <= 1'b0;
         pc_reg <= '0;
         ls_en <= 1'b0;
         ls_idx <= '0;
         ls_start <= '0;
         ls_cnt <= '0;
         ls_ptr <= '0;
         ls_base <= '0;
         pos_prev <= '0;
         tick_cnt <= '0;
         ack <= 1'b0;
      end else begin
         drv <= next_drv;
         lvl <= next_lvl;
         pen <= next_pen;
         pup <= next_pup;
         pc_en <= next_pc_en;
         pc_reg <= next_pc_reg;
         ls_en <= next_ls_en;
         ls_idx <= next_ls_idx;
         ls_start <= next_ls_start;
         ls_cnt <= next_ls_cnt;
         ls_ptr <= next_ls_ptr;
         ls_base <= next_ls_base;
         pos_prev <= next_pos_prev;
         tick_cnt <= next_tick_cnt;
         ack <= next_ack;
      end
   end

   assign line_out = lvl;
   assign line_oe_n_out = ~drv;
   assign pull_en_out = pen;
   assign pull_up_out = pup;
   assign pc_active_out = pc_en;
   assign ls_active_out = ls_en;
   assign cmd_ack_out = ack;

   // checks on the command decode and engines
   a_reset_all_in: assert property (@(posedge ref_clk_in) $past(rst_in) |-> line_oe_n_out == '1) // RL2
      else $error("line driven right after reset");
   a_cfg_input: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RL1
      cmd_valid_in && cmd_code_in == CODE_CFG && cmd_sel[5] && cmd_arg1_in == MODE_IN
      |=> line_oe_n_out[$past(cmd_sel[4:0])] && cmd_ack_out)
      else $error("input mode did not release line");
   a_cfg_low: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RL3
      cmd_valid_in && cmd_code_in == CODE_CFG && cmd_sel[5] && cmd_arg1_in == MODE_LOW
      |=> !line_oe_n_out[$past(cmd_sel[4:0])] && !line_out[$past(cmd_sel[4:0])])
      else $error("low mode did not drive low");
   a_ext_high_off: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RL4
      cmd_valid_in && cmd_code_in == CODE_CFG && cmd_arg1_in == MODE_HIGH
      && cmd_arg0_in >= EXT_FIRST && cmd_arg0_in <= EXT_LAST
      |=> line_oe_n_out[$past(cmd_sel[4:0])])
      else $error("open collector line driven in high mode");
   a_pull_up_set: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RL6
      cmd_valid_in && cmd_code_in == CODE_CFG && cmd_sel[5] && cmd_arg1_in == MODE_PU
      |=> pull_en_out[$past(cmd_sel[4:0])] && pull_up_out[$past(cmd_sel[4:0])])
      else $error("pull-up not applied");
   a_clr_drive: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RL7
      cmd_valid_in && cmd_code_in == CODE_CLR && cmd_sel[5]
      |=> !line_oe_n_out[$past(cmd_sel[4:0])] && !line_out[$past(cmd_sel[4:0])])
      else $error("clear did not drive low");
   a_pcp_stop: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RL14
      cmd_valid_in && cmd_code_in == CODE_PCP && cmd_arg0_in == 16'h0000 |=> !pc_active_out)
      else $error("compare still running after disable");
   a_ls_stop: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RL16
      cmd_valid_in && (cmd_code_in == CODE_LS || cmd_code_in == CODE_LT)
      && cmd_arg0_in == 16'h0000 |=> !ls_active_out ##1 !ls_active_out || $past(cmd_valid_in))
      else $error("limit switch still running after disable");
   a_tick_spacing: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RL13
      tick |=> !tick [*8])
      else $error("compare ticks too close");
   a_pc_zero_mod: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RL10
      pc_en && tick && !cmd_valid_in && mem[REG_AW'(pc_reg + 5'h01)] == 0
      |=> line_out[0] == ($past($signed(pos_in)) >= $past(mem[pc_reg])))
      else $error("zero modulo compare level wrong");
   a_ack_only_known: assert property (@(posedge ref_clk_in) disable iff (rst_in) // RL20
      cmd_ack_out |-> $past(cmd_valid_in))
      else $error("acknowledge without command");
endmodule

/* File: tb/iocpc_host.sv */
// host model issuing one-cycle commands on the command port
`timescale 1ns/1ns
module iocpc_host (
   input wire logic clk_in,
   input wire logic ack_in,
   output logic valid_out,
   output logic [7:0] code_out,
   output logic [15:0] a0_out,
   output logic [15:0] a1_out,
   output logic [15:0] a2_out,
   output logic [15:0] a3_out,
   output logic acked_out
);
   initial begin
      valid_out = 1'b0;
      code_out = 8'h00;
      {a0_out, a1_out, a2_out, a3_out} = 64'h0;
      acked_out = 1'b0;
   end
   // one command per call; args held through the taking edge, ack seen the cycle after
   task automatic send(input logic [7:0] c, input logic [15:0] p0, p1, p2, p3);
      @(negedge clk_in);
      valid_out = 1'b1;
      code_out = c;
      {a0_out, a1_out, a2_out, a3_out} = {p0, p1, p2, p3};
      @(negedge clk_in);
      valid_out = 1'b0;
      // released args are inverted so stale values never look valid
      {a0_out, a1_out, a2_out, a3_out} = ~{p0, p1, p2, p3};
      acked_out = ack_in;
   endtask
endmodule

/* File: tb/tb_iocpc_top.sv */
// self-checking bench for the line configuration and position compare block
`timescale 1ns/1ns
module tb_iocpc_top
   import iocpc_pkg::*;
;
   localparam int TK = 16;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic cmd_valid, cmd_ack, acked, usr_wr, pc_act, ls_act;
   logic [7:0] cmd_code;
   logic [15:0] a0, a1, a2, a3;
   logic [31:0] pos, usr_data, rdata;
   logic [REG_AW-1:0] usr_addr;
   logic [N_LINE-1:0] lin, lout, oe_n, pen, pup, lst, e_oe_n, e_out, e_pen, e_pup;
   logic [15:0] modes [6] = '{MODE_IN, MODE_LOW, MODE_HIGH, MODE_PU, MODE_PD, MODE_PI};
   logic [31:0] seed = 32'h49;
   int fails = 0;
   int compares = 0;
   int cyc = 0;
   iocpc_top #(.TICK_CYCLES(TK)) dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid),
      .cmd_code_in(cmd_code), .cmd_arg0_in(a0), .cmd_arg1_in(a1), .cmd_arg2_in(a2), .cmd_arg3_in(a3),
      .cmd_ack_out(cmd_ack), .pos_in(pos), .usr_wr_in(usr_wr), .usr_addr_in(usr_addr),
      .usr_data_in(usr_data), .usr_rdata_out(rdata), .line_in(lin), .line_out(lout),
      .line_oe_n_out(oe_n), .pull_en_out(pen), .pull_up_out(pup), .line_state_out(lst),
      .pc_active_out(pc_act), .ls_active_out(ls_act));
   iocpc_host host (.clk_in(ref_clk_in), .ack_in(cmd_ack), .valid_out(cmd_valid), .code_out(cmd_code),
      .a0_out(a0), .a1_out(a1), .a2_out(a2), .a3_out(a3), .acked_out(acked));
   always #10 ref_clk_in = ~ref_clk_in;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // expected line state after one command; drive level only matters where driving
   task automatic model(input int i, input logic [7:0] c, input logic [15:0] m);
      if (c == CODE_CLR || m == MODE_LOW) begin
         e_oe_n[i] = 1'b0;
         e_out[i] = 1'b0;
      end else if (m == MODE_HIGH) begin
         e_oe_n[i] = EXT_MASK[i];
         e_out[i] = 1'b1;
      end else if (m == MODE_IN) begin
         e_oe_n[i] = 1'b1;
      end else begin
         e_pen[i] = (m != MODE_PI);
         e_pup[i] = (m == MODE_PU);
      end
   endtask
   task automatic cmpv();
      chk("line_oe_n", 32'(e_oe_n), 32'(oe_n));
      chk("line_out", 32'(e_out & ~e_oe_n), 32'(lout & ~e_oe_n));
      chk("pull_en", 32'(e_pen), 32'(pen));
      chk("pull_up", 32'(e_pup & e_pen), 32'(pup & e_pen));
   endtask
   task automatic cmd(input logic [7:0] c, input logic [15:0] p0, p1, p2, p3, input logic ea);
      host.send(c, p0, p1, p2, p3);
      chk("cmd_ack", 32'(ea), 32'(acked));
   endtask
   // configure by line index, tracking expectation
   task automatic cfg(input int i, input logic [7:0] c, input logic [15:0] m);
      cmd(c, (i < N_STD) ? 16'(i + 1) : 16'(i + 93), m, 16'h0, 16'h0, 1'b1);
      model(i, c, m);
      cmpv();
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(negedge ref_clk_in);
      usr_wr = 1'b1;
      usr_addr = a;
      usr_data = d;
      @(negedge ref_clk_in);
      usr_wr = 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      @(negedge ref_clk_in);
      usr_addr = a;
      @(negedge ref_clk_in);
      chk("usr_rdata", e, rdata);
   endtask
   // hold a position for two ticks so the previous sample catches up
   task automatic go(input logic [31:0] p);
      @(negedge ref_clk_in);
      pos = p;
      repeat (2 * TK) @(negedge ref_clk_in);
   endtask
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 10000) begin
         fails++;
         complete_run();
      end
   end
   initial begin
      {pos, usr_data, usr_addr, usr_wr, lin} = '0;
      {e_oe_n, e_out, e_pen, e_pup} = {{N_LINE{1'b1}}, {3 * N_LINE{1'b0}}};
      repeat (4) @(negedge ref_clk_in);
      rst_in = 1'b0;
      cmpv();
      cmd(CODE_CFG, 16'h0009, MODE_LOW, 16'h0, 16'h0, 1'b0);
      cmd(CODE_CFG, 16'h0003, 16'h0005, 16'h0, 16'h0, 1'b0);
      cfg(3, CODE_CLR, 16'h0);
      for (int j = 0; j < 6; j++) begin
         cfg(2, CODE_CFG, modes[j]);
         cfg(8, CODE_CFG, modes[j]);
      end
      for (int k = 0; k < 40; k++) begin
         seed = xs(seed);
         cfg(int'(seed[7:0]) % N_LINE, (seed[10:8] == 3'h7) ? CODE_CLR : CODE_CFG, modes[seed[15:12] % 6]);
      end
      cfg(9, CODE_CFG, MODE_LOW);
      seed = xs(seed);
      lin = seed[N_LINE-1:0] | 24'h000200;
      repeat (3) @(negedge ref_clk_in);
      chk("line_state", 32'(lin), 32'(lst));
      cfg(0, CODE_CFG, MODE_LOW);
      wr(5'h1c, 32'h64);
      wr(5'h1d, 32'h32);
      go(32'h5a);
      cmd(CODE_PCP, 16'h001c, 16'h0, 16'h0, 16'h0, 1'b1);
      chk("pc_active", 32'h1, 32'(pc_act));
      go(32'h6e);
      chk("line1", 32'h1, 32'(lout[0]));
      rd(5'h1c, 32'h96);
      go(32'h8c);
      chk("line1", 32'h1, 32'(lout[0]));
      wr(5'h1c, 32'h64);
      go(32'h32);
      chk("line1", 32'h0, 32'(lout[0]));
      rd(5'h1c, 32'h32);
      cmd(CODE_PCP, 16'h0000, 16'h0, 16'h0, 16'h0, 1'b1);
      chk("pc_active", 32'h0, 32'(pc_act));
      go(32'h12c);
      chk("line1", 32'h0, 32'(lout[0]));
      wr(5'h04, 32'h3e8);
      wr(5'h05, 32'h0);
      cmd(CODE_PCP, 16'h0004, 16'h0, 16'h0, 16'h0, 1'b1);
      go(32'h44c);
      chk("line1", 32'h1, 32'(lout[0]));
      rd(5'h04, 32'h3e8);
      go(32'h384);
      chk("line1", 32'h0, 32'(lout[0]));
      cmd(CODE_PCP, 16'h0000, 16'h0, 16'h0, 16'h0, 1'b1);
      // table 100, 200 with a span of 1000 driving line 2
      wr(5'h0a, 32'h64);
      wr(5'h0b, 32'hc8);
      wr(5'h0c, 32'h3e8);
      go(32'h0);
      cmd(CODE_LS, 16'h0002, 16'h0, 16'h000a, 16'h0002, 1'b1);
      chk("ls_active", 32'h1, 32'(ls_act));
      go(32'h96);
      chk("line2", 32'h1, 32'(lout[1]));
      go(32'hfa);
      chk("line2", 32'h0, 32'(lout[1]));
      go(32'h41a);
      chk("line2", 32'h0, 32'(lout[1]));
      go(32'h47e);
      chk("line2", 32'h1, 32'(lout[1]));
      // recount to one point: level reloads, span base of 1000 must survive
      cmd(CODE_LT, 16'h0002, 16'h0, 16'h0001, 16'h0, 1'b1);
      chk("line2", 32'h0, 32'(lout[1]));
      chk("ls_active", 32'h1, 32'(ls_act));
      go(32'h47e);
      chk("line2", 32'h1, 32'(lout[1]));
      go(32'h51e);
      chk("line2", 32'h0, 32'(lout[1]));
      cmd(CODE_LT, 16'h0000, 16'h0, 16'h0002, 16'h0, 1'b1);
      chk("ls_active", 32'h0, 32'(ls_act));
      // reset again mid-run with compare running: lines back to inputs, engines off
      cmd(CODE_PCP, 16'h001c, 16'h0, 16'h0, 16'h0, 1'b1);
      @(negedge ref_clk_in);
      rst_in = 1'b1;
      repeat (2) @(negedge ref_clk_in);
      rst_in = 1'b0;
      {e_oe_n, e_out, e_pen, e_pup} = {{N_LINE{1'b1}}, {3 * N_LINE{1'b0}}};
      cmpv();
      chk("pc_active", 32'h0, 32'(pc_act));
      chk("ls_active", 32'h0, 32'(ls_act));
      complete_run();
   end
endmodule
